// File: core/mos_cond_mux.v
`timescale 1ns/100ps
`include "mos_defs.vh"

module mos_cond_mux #(
    parameter NC = `MOS_NUM_COND,
    parameter SW = `MOS_SEL_W
) (
    input wire [NC-1:0] condVec,
    input wire [SW-1:0] sel,
    output wire selOut
);
    // codes past the table give a quiet output rather than an x
    assign selOut = (sel < NC) ? condVec[sel] : 1'b0;
endmodule // mos_cond_mux

// File: core/mos_defs.vh
`ifndef MOS_DEFS_VH
`define MOS_DEFS_VH

// register byte offsets
`define MOS_REG_LEVEL 8'h00
`define MOS_REG_BANDWIDTH 8'h04
`define MOS_REG_MAXFREQ 8'h08
`define MOS_REG_SELECT 8'h0c
`define MOS_REG_FAULTMASK 8'h10
`define MOS_REG_STATUS 8'h14
`define MOS_REG_ERROR 8'h18

// frequencies are held in 0.1 Hz steps
`define MOS_FREQ_W 16
`define MOS_FREQ_LIMIT 16'h0fa0
`define MOS_LEVEL_RST 16'h012c
`define MOS_BANDWIDTH_RST 16'h0064
`define MOS_MAXFREQ_RST 16'h0258

// selector field layout and codes
`define MOS_SEL_W 5
`define MOS_SEL_TR_LSB 0
`define MOS_SEL_RL_LSB 8
`define MOS_SEL_MAX 5'h11
`define MOS_SEL_TR_RST 5'h0c
`define MOS_SEL_RL_RST 5'h11
`define MOS_NUM_COND 18

// condition codes
`define MOS_C_SPEED_MATCH 0
`define MOS_C_LEVEL_MATCH 1
`define MOS_C_LEVEL_WINDOW 2
`define MOS_C_THRESHOLD 3
`define MOS_C_THRESHOLD_INV 4
`define MOS_C_OVERLOAD_WARN 5
`define MOS_C_DRIVE_OVERLOAD 6
`define MOS_C_STALL 7
`define MOS_C_OVERVOLT 8
`define MOS_C_LOWVOLT 9
`define MOS_C_HEATSINK 10
`define MOS_C_CMD_LOST 11
`define MOS_C_RUN 12
`define MOS_C_STOP 13
`define MOS_C_STEADY 14
`define MOS_C_SEARCH 15
`define MOS_C_WAIT_RUN 16
`define MOS_C_FAULT 17

// fault relay mask
`define MOS_MASK_W 3
`define MOS_MASK_RST 3'h2
`define MOS_MASK_LV 0
`define MOS_MASK_TRIP 1
`define MOS_MASK_RESTART 2

// status and error bits
`define MOS_ST_TR 0
`define MOS_ST_RL 1
`define MOS_ST_FDT_LSB 2
`define MOS_ERR_REFUSED 0

`endif

// File: core/mos_freq_detect.v
`timescale 1ns/100ps
`include "mos_defs.vh"

module mos_freq_detect #(
    parameter FW = `MOS_FREQ_W
) (
    input wire clk,
    input wire rst,
    input wire [FW-1:0] presetFreq,
    input wire [FW-1:0] runFreq,
    input wire [FW-1:0] level,
    input wire [FW-1:0] bandwidth,
    output wire speedMatch,
    output wire levelMatch,
    output wire levelWindow,
    output wire levelThreshold
);
    wire [FW-1:0] halfBand;
    wire [FW-1:0] diffPreset;
    wire [FW-1:0] diffLevel;
    wire [FW:0] lowEdge;
    reg thresh_q;
    wire thresh_d;

    // absolute differences, no sign bit needed as operands are unsigned
    assign halfBand = bandwidth >> 1;
    assign diffPreset = (presetFreq > runFreq) ? presetFreq - runFreq : runFreq - presetFreq;
    assign diffLevel = (level > runFreq) ? level - runFreq : runFreq - level;
    assign speedMatch = diffPreset <= halfBand;
    assign levelMatch = (presetFreq == level) && speedMatch;
    assign levelWindow = diffLevel <= halfBand;

    // extra bit keeps level minus half band from wrapping below zero
    assign lowEdge = {1'b0, level} - {1'b0, halfBand};
    // rising needs the full level, falling holds while above the low edge and drops at it
    assign thresh_d = (runFreq >= level) ||
        (thresh_q && (lowEdge[FW] || ({1'b0, runFreq} > lowEdge)));
    assign levelThreshold = thresh_q;

    // one flop of hysteresis memory
    always @(posedge clk)
    begin
        if (rst)
            thresh_q <= 1'b0;
        else
            thresh_q <= thresh_d;
    end
endmodule // mos_freq_detect

// File: core/mos_output_selector.v
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`include "mos_defs.vh"

module mos_output_selector #(
    parameter FW = `MOS_FREQ_W,
    parameter AW = 8
) (
    input wire clk,
    input wire rst,
    input wire [AW-1:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output wire [31:0] readdata,
    output wire waitrequest,
    input wire [FW-1:0] presetFreq,
    input wire [FW-1:0] outputFreq,
    input wire accelerating,
    input wire decelerating,
    input wire overloadWarning,
    input wire driveOverload,
    input wire stallActive,
    input wire overvoltageTrip,
    input wire lowvoltageTrip,
    input wire heatsinkOvertemp,
    input wire otherTrip,
    input wire commandLost,
    input wire runCommand,
    input wire outputActive,
    input wire speedSearch,
    input wire [7:0] autoRestartTries,
    output wire transistorOutput,
    output wire relayOutput
);
    reg [FW-1:0] level_q;
    reg [FW-1:0] bandwidth_q;
    reg [FW-1:0] maxFreq_q;
    reg [`MOS_SEL_W-1:0] trSel_q;
    reg [`MOS_SEL_W-1:0] rlSel_q;
    reg [`MOS_MASK_W-1:0] faultMask_q;
    reg refused_q;
    reg refused_d;
    reg waitreq_q;
    reg [31:0] readdata_q;
    reg [31:0] readdata_d;
    reg trOut_q;
    reg rlOut_q;
    wire accept;
    wire writeNow;
    wire [31:0] wrMerged;
    reg [31:0] regOld;
    wire [FW-1:0] wrFreq;
    wire [`MOS_SEL_W-1:0] wrTrSel;
    wire [`MOS_SEL_W-1:0] wrRlSel;
    wire speedMatch;
    wire levelMatch;
    wire levelWindow;
    wire levelThreshold;
    wire faultActive;
    wire anyTrip;
    wire trSelOut;
    wire rlSelOut;
    wire [`MOS_NUM_COND-1:0] condVec;
    wire [31:0] statusWord;

    // one wait state: waitrequest drops on the cycle after a request arrives
    assign accept = (read || write) && waitreq_q;
    assign writeNow = write && !waitreq_q;
    assign waitrequest = waitreq_q;
    assign readdata = readdata_q;
    assign transistorOutput = trOut_q;
    assign relayOutput = rlOut_q;

    // waitrequest idles high; the request edge drops it for one cycle only
    always @(posedge clk)
    begin
        if (rst)
            waitreq_q <= 1'b1;
        else
            waitreq_q <= !accept;
    end

    // current value of the addressed register, for byte-lane merging
    always @*
    begin
        case (address)
            `MOS_REG_LEVEL: regOld = {{(32-FW){1'b0}}, level_q};
            `MOS_REG_BANDWIDTH: regOld = {{(32-FW){1'b0}}, bandwidth_q};
            `MOS_REG_MAXFREQ: regOld = {{(32-FW){1'b0}}, maxFreq_q};
            `MOS_REG_SELECT: regOld = {19'h0, rlSel_q, 3'h0, trSel_q};
            `MOS_REG_FAULTMASK: regOld = {29'h0, faultMask_q};
            default: regOld = 32'h0;
        endcase
    end

    // only enabled byte lanes change; others keep the stored value
    assign wrMerged = {byteenable[3] ? writedata[31:24] : regOld[31:24],
                       byteenable[2] ? writedata[23:16] : regOld[23:16],
                       byteenable[1] ? writedata[15:8] : regOld[15:8],
                       byteenable[0] ? writedata[7:0] : regOld[7:0]};

    // candidate values, range-checked before anything is stored
    assign wrFreq = wrMerged[FW-1:0];
    assign wrTrSel = wrMerged[`MOS_SEL_TR_LSB+`MOS_SEL_W-1:`MOS_SEL_TR_LSB];
    assign wrRlSel = wrMerged[`MOS_SEL_RL_LSB+`MOS_SEL_W-1:`MOS_SEL_RL_LSB];

    // settings; an out-of-range write leaves the old value and flags it
    always @(posedge clk)
    begin
        if (rst)
        begin
            level_q <= `MOS_LEVEL_RST;
            bandwidth_q <= `MOS_BANDWIDTH_RST;
            maxFreq_q <= `MOS_MAXFREQ_RST;
            // pins come up on run indication and fault relay
            trSel_q <= `MOS_SEL_TR_RST;
            rlSel_q <= `MOS_SEL_RL_RST;
            faultMask_q <= `MOS_MASK_RST;
        end
        else if (writeNow)
        begin
            case (address)
                `MOS_REG_LEVEL:
                begin
                    if (wrFreq <= `MOS_FREQ_LIMIT && wrFreq <= maxFreq_q)
                        level_q <= wrFreq;
                end
                `MOS_REG_BANDWIDTH:
                begin
                    if (wrFreq <= `MOS_FREQ_LIMIT && wrFreq <= maxFreq_q)
                        bandwidth_q <= wrFreq;
                end
                `MOS_REG_MAXFREQ:
                begin
                    if (wrFreq <= `MOS_FREQ_LIMIT)
                        maxFreq_q <= wrFreq;
                end
                `MOS_REG_SELECT:
                begin
                    if (wrTrSel <= `MOS_SEL_MAX && wrRlSel <= `MOS_SEL_MAX)
                    begin
                        trSel_q <= wrTrSel;
                        rlSel_q <= wrRlSel;
                    end
                end
                // every three-bit mask is legal, so nothing is refused here
                `MOS_REG_FAULTMASK: faultMask_q <= wrMerged[`MOS_MASK_W-1:0];
                default: ;
            endcase
        end
    end

    // refused flag: a new refusal in the clearing cycle wins over the clear
    always @*
    begin
        refused_d = refused_q;
        // the clear comes first so that a refusal below overrides it
        if (writeNow && address == `MOS_REG_ERROR && byteenable[0] &&
            writedata[`MOS_ERR_REFUSED])
            refused_d = 1'b0;
        if (writeNow)
        begin
            case (address)
                `MOS_REG_LEVEL, `MOS_REG_BANDWIDTH:
                    if (wrFreq > `MOS_FREQ_LIMIT || wrFreq > maxFreq_q)
                        refused_d = 1'b1;
                `MOS_REG_MAXFREQ:
                    if (wrFreq > `MOS_FREQ_LIMIT)
                        refused_d = 1'b1;
                `MOS_REG_SELECT:
                    if (wrTrSel > `MOS_SEL_MAX || wrRlSel > `MOS_SEL_MAX)
                        refused_d = 1'b1;
                default: ;
            endcase
        end
    end

    // sticky until software writes a one to clear it
    always @(posedge clk)
    begin
        if (rst)
            refused_q <= 1'b0;
        else
            refused_q <= refused_d;
    end

    // frequency comparisons on the running output frequency
    mos_freq_detect #(
        .FW(FW)
    ) uFreqDetect (
        .clk(clk),
        .rst(rst),
        .presetFreq(presetFreq),
        .runFreq(outputFreq),
        .level(level_q),
        .bandwidth(bandwidth_q),
        .speedMatch(speedMatch),
        .levelMatch(levelMatch),
        .levelWindow(levelWindow),
        .levelThreshold(levelThreshold)
    );

    // fault relay function built from the mask bits
    assign anyTrip = lowvoltageTrip || otherTrip;
    assign faultActive = (faultMask_q[`MOS_MASK_LV] && lowvoltageTrip) ||
        (faultMask_q[`MOS_MASK_TRIP] && otherTrip) ||
        (faultMask_q[`MOS_MASK_RESTART] && (autoRestartTries != 8'h00));

    // condition table indexed by selector code
    assign condVec[`MOS_C_SPEED_MATCH] = speedMatch;
    assign condVec[`MOS_C_LEVEL_MATCH] = levelMatch;
    assign condVec[`MOS_C_LEVEL_WINDOW] = levelWindow;
    assign condVec[`MOS_C_THRESHOLD] = levelThreshold;
    assign condVec[`MOS_C_THRESHOLD_INV] = !levelThreshold;
    assign condVec[`MOS_C_OVERLOAD_WARN] = overloadWarning;
    assign condVec[`MOS_C_DRIVE_OVERLOAD] = driveOverload;
    assign condVec[`MOS_C_STALL] = stallActive;
    assign condVec[`MOS_C_OVERVOLT] = overvoltageTrip;
    assign condVec[`MOS_C_LOWVOLT] = lowvoltageTrip;
    assign condVec[`MOS_C_HEATSINK] = heatsinkOvertemp;
    assign condVec[`MOS_C_CMD_LOST] = commandLost;
    assign condVec[`MOS_C_RUN] = runCommand && outputActive;
    assign condVec[`MOS_C_STOP] = !runCommand && !outputActive;
    assign condVec[`MOS_C_STEADY] = outputActive && !accelerating && !decelerating;
    assign condVec[`MOS_C_SEARCH] = speedSearch;
    assign condVec[`MOS_C_WAIT_RUN] = !anyTrip && !runCommand;
    assign condVec[`MOS_C_FAULT] = faultActive;

    // one selector per output terminal
    mos_cond_mux uTrMux (
        .condVec(condVec),
        .sel(trSel_q),
        .selOut(trSelOut)
    );

    // the relay shares the table; both pins may pick the same code
    mos_cond_mux uRlMux (
        .condVec(condVec),
        .sel(rlSel_q),
        .selOut(rlSelOut)
    );

    // outputs follow the selected condition each cycle, one flop late
    always @(posedge clk)
    begin
        if (rst)
        begin
            trOut_q <= 1'b0;
            rlOut_q <= 1'b0;
        end
        else
        begin
            trOut_q <= trSelOut;
            rlOut_q <= rlSelOut;
        end
    end

    // live view of both pins and the four frequency comparisons
    assign statusWord = {26'h0, levelThreshold, levelWindow, levelMatch, speedMatch,
                         rlOut_q, trOut_q};

    // read data is loaded as waitrequest drops, so it stands at the handshake edge
    always @*
    begin
        case (address)
            `MOS_REG_STATUS: readdata_d = statusWord;
            `MOS_REG_ERROR: readdata_d = {31'h0, refused_q};
            default: readdata_d = regOld;
        endcase
    end

    // only a taken read reloads it, so the word stands until the next read
    always @(posedge clk)
    begin
        if (rst)
            readdata_q <= 32'h0;
        else if (accept && read)
            readdata_q <= readdata_d;
    end
endmodule // mos_output_selector

// File: dv/mos_checker.sv
`timescale 1ns/100ps
module mos_checker (
    input logic clk,
    input logic rst,
    input logic [7:0] address,
    input logic read,
    input logic write,
    input logic [31:0] writedata,
    input logic [31:0] readdata,
    input logic waitrequest,
    input logic lowvoltageTrip,
    input logic otherTrip,
    input logic runCommand,
    input logic outputActive,
    input logic speedSearch,
    input logic [7:0] autoRestartTries,
    input logic transistorOutput,
    input logic relayOutput
);
    logic [4:0] trSel_q, rlSel_q, trPrev_q, rlPrev_q, cond_q;
    logic [2:0] mask_q;
    logic wrDone;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    assign wrDone = write && !waitrequest;
    // shadow copies assume full-word writes to select and mask
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            trSel_q <= 5'h0c;
            rlSel_q <= 5'h11;
            mask_q <= 3'h2;
        end
        else if (wrDone && address == 8'h0c && writedata[4:0] < 5'h12
            && writedata[12:8] < 5'h12)
        begin
            trSel_q <= writedata[4:0];
            rlSel_q <= writedata[12:8];
        end
        else if (wrDone && address == 8'h10)
            mask_q <= writedata[2:0];
        trPrev_q <= trSel_q;
        rlPrev_q <= rlSel_q;
        cond_q <= {!lowvoltageTrip && !otherTrip && !runCommand, speedSearch,
            !runCommand && !outputActive, runCommand && outputActive,
            |(mask_q & {autoRestartTries != 8'h00, otherTrip, lowvoltageTrip})};
    end
    sequence s_ans;
        !waitrequest ##1 waitrequest;
    endsequence
    property p_take;
        (read || write) && waitrequest |=> s_ans;
    endproperty
    a_take: assert property (p_take) else $error("answer not one cycle");
    property p_hole;
        read && waitrequest && address > 8'h18 |=> readdata == 32'h0;
    endproperty
    a_hole: assert property (p_hole) else $error("unmapped read not zero");
    property p_run;
        !$past(rst) && trPrev_q == 5'h0c |-> transistorOutput == cond_q[1];
    endproperty
    a_run: assert property (p_run) else $error("run output wrong");
    property p_stop;
        !$past(rst) && trPrev_q == 5'h0d |-> transistorOutput == cond_q[2];
    endproperty
    a_stop: assert property (p_stop) else $error("stop output wrong");
    property p_search;
        !$past(rst) && trPrev_q == 5'h0f |-> transistorOutput == cond_q[3];
    endproperty
    a_search: assert property (p_search) else $error("search output wrong");
    property p_wait;
        !$past(rst) && trPrev_q == 5'h10 |-> transistorOutput == cond_q[4];
    endproperty
    a_wait: assert property (p_wait) else $error("wait output wrong");
    property p_fault;
        !$past(rst) && rlPrev_q == 5'h11 |-> relayOutput == cond_q[0];
    endproperty
    a_fault: assert property (p_fault) else $error("fault relay wrong");
    property p_inv;
        !$past(rst) && trPrev_q == 5'h03 && rlPrev_q == 5'h04 |-> relayOutput != transistorOutput;
    endproperty
    a_inv: assert property (p_inv) else $error("inverted threshold wrong");
endmodule // mos_checker

bind mos_output_selector mos_checker mos_checker_inst (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .lowvoltageTrip(lowvoltageTrip), .otherTrip(otherTrip), .runCommand(runCommand),
    .outputActive(outputActive), .speedSearch(speedSearch),
    .autoRestartTries(autoRestartTries), .transistorOutput(transistorOutput),
    .relayOutput(relayOutput)
);

// File: dv/mos_output_selector_tb_top.sv
`timescale 1ns/100ps
module mos_output_selector_tb_top;
    logic clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
    logic [7:0] address = 8'h00, tries = 8'h00;
    logic [31:0] writedata = 32'h0, rd, readdata;
    logic [3:0] byteenable = 4'hf;
    logic [15:0] pf = 16'h0, of = 16'h0;
    logic [12:0] fl = 13'h0;
    logic [2:0] mk;
    logic [4:0] hyExp = 5'h0c;
    logic waitrequest, runCommand, trOut, rlOut;
    logic [31:0] regRst [8] = '{32'h12c, 32'h64, 32'h258, 32'h110c, 32'h2, 32'h4, 32'h0, 32'h0};
    logic [15:0] hyFreq [5] = '{16'hc8, 16'h12b, 16'h12c, 16'hfb, 16'hfa};
    int c, n_fail = 0, check_count = 0;

    // 125 MHz control clock
    always #4 clk = ~clk;

    mos_seq_model mos_seq_model_inst (.clk(clk), .rst(rst), .runWanted(fl[10]),
        .runCommand(runCommand));
    mos_output_selector mos_output_selector_inst (
        .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .presetFreq(pf), .outputFreq(of),
        .accelerating(fl[0]), .decelerating(fl[1]), .overloadWarning(fl[2]),
        .driveOverload(fl[3]), .stallActive(fl[4]), .overvoltageTrip(fl[5]),
        .lowvoltageTrip(fl[6]), .heatsinkOvertemp(fl[7]), .commandLost(fl[8]),
        .otherTrip(fl[9]), .runCommand(runCommand), .outputActive(fl[11]),
        .speedSearch(fl[12]), .autoRestartTries(tries), .transistorOutput(trOut),
        .relayOutput(rlOut));

    // expected pin level for a code, level 30.0 Hz and bandwidth 10.0 Hz
    function automatic logic expc(input int k);
        logic [15:0] dp, dl;
        dp = (pf > of) ? pf - of : of - pf;
        dl = (of > 16'h12c) ? of - 16'h12c : 16'h12c - of;
        case (k)
            0: expc = dp <= 16'h32;
            1: expc = pf == 16'h12c && dp <= 16'h32;
            2: expc = dl <= 16'h32;
            12: expc = runCommand && fl[11];
            13: expc = !runCommand && !fl[11];
            14: expc = fl[11] && !fl[0] && !fl[1];
            15: expc = fl[12];
            16: expc = !fl[6] && !fl[9] && !runCommand;
            17: expc = |(mk & {tries != 8'h00, fl[9], fl[6]});
            default: expc = fl[k - 3];
        endcase
    endfunction

    // one bus cycle; the request stands until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] be);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= wr;
        read <= !wr;
        @(posedge clk);
        // only the run's own timeout ends this wait
        while (waitrequest !== 1'b0)
            @(posedge clk);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, 4'hf);
        check("readdata", rd, e);
    endtask

    task automatic final_report;
        if (n_fail == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // cut a hang short; the tests need fewer than six hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        final_report;
    end

    initial
    begin
        void'($urandom(32'h95b5));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // reset values, then one unmapped offset
        for (int i = 0; i < 8; i++)
            rdchk(8'(i * 4), regRst[i]);
        // every non-threshold code under random status, mask and frequencies
        for (int i = 0; i < 54; i++)
        begin
            c = i % 18;
            if (c == 3 || c == 4)
                continue;
            mk = 3'($urandom);
            bus(1'b1, 8'h0c, {19'h0, 5'h11, 3'h0, 5'(c)}, 4'hf);
            bus(1'b1, 8'h10, {29'h0, mk}, 4'hf);
            fl <= 13'($urandom);
            tries <= (i % 3 == 0) ? 8'h00 : 8'($urandom);
            pf <= (i % 2 == 1) ? 16'h12c : 16'(250 + $urandom % 100);
            of <= 16'(250 + $urandom % 100);
            repeat (4) @(posedge clk);
            check("trOut", trOut, expc(c));
            check("rlOut", rlOut, expc(17));
        end
        // rising and falling threshold on one pin, its inverse on the other
        bus(1'b1, 8'h0c, 32'h0403, 4'hf);
        for (int i = 0; i < 5; i++)
        begin
            of <= hyFreq[i];
            repeat (4) @(posedge clk);
            check("thr", trOut, hyExp[i]);
            check("thrInv", rlOut, !hyExp[i]);
        end
        // refused writes keep the old value and raise the error flag
        bus(1'b1, 8'h0c, 32'h1112, 4'hf);
        rdchk(8'h0c, 32'h403);
        rdchk(8'h18, 32'h1);
        bus(1'b1, 8'h18, 32'h1, 4'hf);
        rdchk(8'h18, 32'h0);
        bus(1'b1, 8'h04, 32'h259, 4'hf);
        rdchk(8'h04, 32'h64);
        bus(1'b1, 8'h08, 32'hfa0, 4'hf);
        bus(1'b1, 8'h04, 32'hfa0, 4'hf);
        rdchk(8'h04, 32'hfa0);
        bus(1'b1, 8'h08, 32'hfa1, 4'hf);
        rdchk(8'h08, 32'hfa0);
        // a single-lane write merges into the stored level
        bus(1'b1, 8'h00, 32'h0, 4'h2);
        rdchk(8'h00, 32'h2c);
        final_report;
    end
endmodule // mos_output_selector_tb_top

// File: dv/mos_seq_model.sv
`timescale 1ns/100ps
module mos_seq_model (
    input logic clk,
    input logic rst,
    input logic runWanted,
    output logic runCommand
);
    // the sequence closes its run contact one cycle after it decides to run
    always_ff @(posedge clk)
        runCommand <= rst ? 1'b0 : runWanted;
endmodule // mos_seq_model
